// ===== rtl/cswr_top.sv
// Clock source switch controller with reference clock output divider
// How it works
// - Switching enabled only when switch_enable_fuse is 0; fuse 1 disables it.
// - With switching disabled, new source ignored; current shows initial_source_fuse.
// - With switching disabled, switch_request ignores writes and reads zero.
// - A byte write lands only right after its own unlock pair.
// - Equal current and new codes clear switch_request and abort.
// - A valid switch clears the PLL lock flag and clock fail flag.
// - Start new oscillator; wait start-up timer for crystal, lock for PLL.
// - Count ten new-clock cycles before moving the system clock.
// - On completion clear switch_request and copy new into current.
// - Stop old source, except busy low-power RC, enabled secondary or primary selected for an enabled reference.
// - Processor is never stalled; code runs on old clock meanwhile.
// - Primary submode comes from fuses only, never changed at runtime.
// - ref_out_enable drives the divided reference onto ref_clock_pin.
// - ref_divider 0 passes primary clock but halves system clock, code n divides by 2 to the n.
// - ref_source_select 1 picks primary oscillator, 0 the system clock.
// - Reference stops in Sleep unless run-in-sleep, select and primary mode.
// - Source codes use the documented three-bit encoding.
// - Lock flag is one only when the PLL is locked.
`timescale 1ns/1ps
`include "cswr_defs.svh"
module cswr_top
  import cswr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic switch_enable_fuse,
  input wire logic [2:0] initial_source_fuse,
  input wire logic [1:0] primary_submode_fuse,
  input wire logic [7:0] osc_ready,
  input wire logic pll_locked,
  input wire logic new_clk_tick,
  input wire logic pri_clk_tick,
  input wire logic keep_low_power_rc,
  input wire logic clock_fail_event,
  input wire logic sleep_mode,
  output cswr_src_type sys_source,
  output cswr_osc_en_type osc_enable,
  output logic ref_clock_pin
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cswr_src_type current_source_select;
  cswr_src_type new_source_select;
  cswr_state_type state;
  logic switch_request;
  logic secondary_osc_enable;
  logic clock_fail_flag;
  logic lock_flag;
  logic [15:0] ref_output_control_reg;
  logic [1:0] unlock_hi;
  logic [1:0] unlock_lo;
  logic [3:0] settle_cnt;
  logic [15:0] ost_cnt;
  logic [14:0] ref_cnt;
  logic [7:0] run_next;
  logic prev_pri;
  logic cfg_done;
  logic sw_en;
  logic wr_osc;
  logic wr_hi;
  logic wr_lo;
  logic wr_ref;
  logic rd_acc;
  logic needs_pll;
  logic needs_ost;
  logic base_tick;
  logic ref_run;
  logic [31:0] next_prdata;

  // Bus strobes: zero-wait APB, every access completes in its access phase
  assign wr_osc = psel && penable && pwrite && (paddr == `CSWR_OFF_OSC);
  assign wr_hi = wr_osc && pstrb[1];
  assign wr_lo = wr_osc && pstrb[0];
  assign wr_ref = psel && penable && pwrite && (paddr == `CSWR_OFF_REF);
  assign rd_acc = psel && !penable && !pwrite;
  assign sw_en = cfg_done && !switch_enable_fuse;
  assign needs_pll = (new_source_select == cswr_src_pri_pll) ||
                     (new_source_select == cswr_src_frc_pll);
  assign needs_ost = (new_source_select == cswr_src_pri) ||
                     (new_source_select == cswr_src_pri_pll) ||
                     (new_source_select == cswr_src_sec);

  // ---------------------------------------------------------------
  // Reset-time fuse capture
  // ---------------------------------------------------------------
  // Fuses are sampled by a clocked process after reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_done <= 1'b0;
    end else begin
      cfg_done <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Unlock sequencers
  // ---------------------------------------------------------------
  // Any other write to the byte drops the armed state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unlock_hi <= 2'd0;
    end else if (wr_hi) begin
      if (unlock_hi == 2'd2) begin
        unlock_hi <= 2'd0;
      end else if (pwdata[15:8] == `CSWR_KEY_H1) begin
        unlock_hi <= 2'd1;
      end else if (unlock_hi == 2'd1 && pwdata[15:8] == `CSWR_KEY_H2) begin
        unlock_hi <= 2'd2;
      end else begin
        unlock_hi <= 2'd0;
      end
    end else if (psel && penable && pwrite) begin
      unlock_hi <= 2'd0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unlock_lo <= 2'd0;
    end else if (wr_lo) begin
      if (unlock_lo == 2'd2) begin
        unlock_lo <= 2'd0;
      end else if (pwdata[7:0] == `CSWR_KEY_L1) begin
        unlock_lo <= 2'd1;
      end else if (unlock_lo == 2'd1 && pwdata[7:0] == `CSWR_KEY_L2) begin
        unlock_lo <= 2'd2;
      end else begin
        unlock_lo <= 2'd0;
      end
    end else if (psel && penable && pwrite) begin
      unlock_lo <= 2'd0;
    end
  end

  // ---------------------------------------------------------------
  // New source select and secondary enable
  // ---------------------------------------------------------------
  // High byte lands only once unlocked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      new_source_select <= cswr_src_frc_div;
    end else if (!cfg_done) begin
      new_source_select <= cswr_src_type'(initial_source_fuse);
    end else if (wr_hi && unlock_hi == 2'd2) begin
      new_source_select <= cswr_src_type'(pwdata[`CSWR_NEW_LSB +: 3]);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      secondary_osc_enable <= 1'b0;
    end else if (wr_lo && unlock_lo == 2'd2) begin
      secondary_osc_enable <= pwdata[`CSWR_BIT_SEC_EN];
    end
  end

  // ---------------------------------------------------------------
  // Switch sequencer
  // ---------------------------------------------------------------
  // The sequencer never holds the bus, so the processor keeps running
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= cswr_idle;
      switch_request <= 1'b0;
      current_source_select <= cswr_src_frc_div;
      settle_cnt <= 4'd0;
      ost_cnt <= 16'd0;
    end else if (!sw_en) begin
      state <= cswr_idle;
      switch_request <= 1'b0;
      current_source_select <= cswr_src_type'(initial_source_fuse);
    end else begin
      unique case (state)
        cswr_idle: begin
          if (wr_lo && unlock_lo == 2'd2 && pwdata[`CSWR_BIT_REQ]) begin
            if (new_source_select == current_source_select) begin
              switch_request <= 1'b0;
            end else begin
              switch_request <= 1'b1;
              state <= cswr_start;
              ost_cnt <= 16'd0;
            end
          end
        end
        cswr_start: begin
          // Crystal waits start-up timer, PLL waits lock
          if (ost_cnt != `CSWR_OST_CYCLES) begin
            ost_cnt <= ost_cnt + 16'd1;
          end
          if (osc_ready[new_source_select] &&
              (!needs_ost || ost_cnt == `CSWR_OST_CYCLES) &&
              (!needs_pll || lock_flag)) begin
            state <= cswr_settle;
            settle_cnt <= 4'd0;
          end
        end
        cswr_settle: begin
          if (new_clk_tick) begin
            settle_cnt <= settle_cnt + 4'd1;
          end
          if (new_clk_tick && settle_cnt == `CSWR_SETTLE_CYCLES - 4'd1) begin
            state <= cswr_swap;
          end
        end
        cswr_swap: begin
          switch_request <= 1'b0;
          current_source_select <= new_source_select;
          state <= cswr_idle;
        end
        default: begin
          state <= cswr_idle;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Fail event set wins over the switch-start clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_fail_flag <= 1'b0;
      lock_flag <= 1'b0;
    end else begin
      if (clock_fail_event && sw_en) begin
        clock_fail_flag <= 1'b1;
      end else if (state == cswr_idle && wr_lo && unlock_lo == 2'd2 &&
                   pwdata[`CSWR_BIT_REQ] && new_source_select != current_source_select) begin
        clock_fail_flag <= 1'b0;
      end
      if (state == cswr_idle && wr_lo && unlock_lo == 2'd2 &&
          pwdata[`CSWR_BIT_REQ] && new_source_select != current_source_select) begin
        lock_flag <= 1'b0;
      end else begin
        lock_flag <= pll_locked && (needs_pll || current_source_select == cswr_src_pri_pll ||
                     current_source_select == cswr_src_frc_pll);
      end
    end
  end

  // ---------------------------------------------------------------
  // Oscillator enables
  // ---------------------------------------------------------------
  // Old source drops after the swap unless an exemption holds it
  always_comb begin
    run_next = 8'h00;
    run_next[current_source_select] = 1'b1;
    if (state != cswr_idle) begin
      run_next[new_source_select] = 1'b1;
    end
    if (keep_low_power_rc) begin
      run_next[cswr_src_low_power_rc_osc] = 1'b1;
    end
    if (secondary_osc_enable) begin
      run_next[cswr_src_sec] = 1'b1;
    end
    if (ref_output_control_reg[`CSWR_REF_SEL] && ref_output_control_reg[`CSWR_REF_EN]) begin
      run_next[cswr_src_pri] = 1'b1;
    end
    if (sleep_mode) begin
      run_next = run_next & 8'h30;
      if (ref_run) begin
        run_next[cswr_src_pri] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_enable <= '0;
      sys_source <= cswr_src_frc_div;
    end else begin
      osc_enable.run <= run_next;
      sys_source <= current_source_select;
    end
  end

  // ---------------------------------------------------------------
  // Reference output
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_output_control_reg <= `CSWR_REF_RESET;
    end else if (wr_ref) begin
      ref_output_control_reg <= pwdata[15:0] & 16'hBF00;
    end
  end

  // Sleep keeps it only with primary configured
  assign ref_run = ref_output_control_reg[`CSWR_REF_EN] &&
                   (!sleep_mode || (ref_output_control_reg[`CSWR_REF_SLP] &&
                    ref_output_control_reg[`CSWR_REF_SEL] &&
                    (current_source_select == cswr_src_pri ||
                     current_source_select == cswr_src_pri_pll)));
  assign base_tick = ref_output_control_reg[`CSWR_REF_SEL] ? pri_clk_tick : 1'b1;

  // Toggle every 2^(n-1) base ticks gives divide by 2^n
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt <= 15'd0;
      ref_clock_pin <= 1'b0;
    end else if (!ref_run) begin
      ref_cnt <= 15'd0;
      ref_clock_pin <= 1'b0;
    end else if (ref_output_control_reg[11:8] == 4'd0) begin
      ref_clock_pin <= ref_output_control_reg[`CSWR_REF_SEL] ? pri_clk_tick : ~ref_clock_pin;
    end else if (base_tick) begin
      if (ref_cnt >= (15'd1 << (ref_output_control_reg[11:8] - 4'd1)) - 15'd1) begin
        ref_cnt <= 15'd0;
        ref_clock_pin <= ~ref_clock_pin;
      end else begin
        ref_cnt <= ref_cnt + 15'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // APB read and answer
  // ---------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `CSWR_OFF_OSC: begin
        next_prdata[14:12] = current_source_select;
        next_prdata[10:8] = new_source_select;
        next_prdata[`CSWR_BIT_LOCK] = lock_flag;
        next_prdata[`CSWR_BIT_FAIL] = clock_fail_flag;
        next_prdata[`CSWR_BIT_SEC_EN] = secondary_osc_enable;
        next_prdata[`CSWR_BIT_REQ] = switch_request;
      end
      `CSWR_OFF_REF: next_prdata[15:0] = ref_output_control_reg;
      `CSWR_OFF_STAT: next_prdata[3:0] = state;
      `CSWR_OFF_CFG: next_prdata[5:0] = {primary_submode_fuse, switch_enable_fuse,
                                         initial_source_fuse};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Data captured in setup phase, so pready and prdata stand in the access phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr[1:0] != 2'd0 || paddr > `CSWR_OFF_CFG);
      if (rd_acc) begin
        prdata <= next_prdata;
      end
    end
  end
endmodule

// ===== rtl/cswr_defs.svh
// Offsets, field positions, reset values and timing counts of the clock switch block
`ifndef CSWR_DEFS_SVH
`define CSWR_DEFS_SVH
`define CSWR_OFF_OSC 12'h000
`define CSWR_OFF_REF 12'h004
`define CSWR_OFF_STAT 12'h008
`define CSWR_OFF_CFG 12'h00C
`define CSWR_KEY_H1 8'h78
`define CSWR_KEY_H2 8'h9A
`define CSWR_KEY_L1 8'h46
`define CSWR_KEY_L2 8'h57
`define CSWR_BIT_REQ 0
`define CSWR_BIT_SEC_EN 1
`define CSWR_BIT_FAIL 3
`define CSWR_BIT_LOCK 5
`define CSWR_NEW_LSB 8
`define CSWR_CUR_LSB 12
`define CSWR_REF_EN 15
`define CSWR_REF_SLP 13
`define CSWR_REF_SEL 12
`define CSWR_REF_DIV_LSB 8
`define CSWR_REF_RESET 16'h0000
`define CSWR_SETTLE_CYCLES 4'd10
`define CSWR_OST_CYCLES 16'd1024
`endif

// ===== rtl/cswr_pkg.sv
// Types shared by the clock switch block
package cswr_pkg;
  typedef enum logic [2:0] {
    cswr_src_frc = 3'h0,
    cswr_src_frc_pll = 3'h1,
    cswr_src_pri = 3'h2,
    cswr_src_pri_pll = 3'h3,
    cswr_src_sec = 3'h4,
    cswr_src_low_power_rc_osc = 3'h5,
    cswr_src_lpfrc_div = 3'h6,
    cswr_src_frc_div = 3'h7
  } cswr_src_type;

  typedef enum logic [3:0] {
    cswr_idle = 4'b0001,
    cswr_start = 4'b0010,
    cswr_settle = 4'b0100,
    cswr_swap = 4'b1000
  } cswr_state_type;

  // Osc enables, one per source code
  typedef struct packed {
    logic [7:0] run;
  } cswr_osc_en_type;
endpackage

// ===== testbench/cswr_sva.sv
// Port-level assertions for the clock switch block
`timescale 1ns/1ps
`include "cswr_defs.svh"
module cswr_sva
  import cswr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic switch_enable_fuse,
  input wire logic new_clk_tick,
  input wire cswr_src_type sys_source,
  input wire cswr_osc_en_type osc_enable
);
  // ------------------------------------------------------------
  // Helpers and properties
  // ------------------------------------------------------------
  logic [1:0] age;
  logic rd_osc;
  // Fuse capture moves sys_source on the second edge, so wait it out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  // Completed read of the oscillator control word
  assign rd_osc = pready && !pwrite && paddr == `CSWR_OFF_OSC && !pslverr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_setup_ready; (psel && !penable) |=> pready; endproperty
  property p_ready_once; pready |=> !pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_unmapped; (psel && !penable && paddr > `CSWR_OFF_CFG) |=> pslverr; endproperty
  property p_hold_off; (age == 2'h3 && switch_enable_fuse) |-> $stable(sys_source); endproperty
  property p_req_zero; (rd_osc && switch_enable_fuse) |-> prdata[0] == 1'b0; endproperty
  property p_cur_mirror;
    (age == 2'h3 && rd_osc) |-> prdata[14:12] == $past(sys_source);
  endproperty
  property p_after_tick;
    (age == 2'h3 && sys_source != $past(sys_source)) |->
      ($past(new_clk_tick) || $past(new_clk_tick, 2) || $past(new_clk_tick, 3));
  endproperty
  property p_new_on;
    (age == 2'h3 && sys_source != $past(sys_source)) |-> osc_enable.run[sys_source];
  endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  a_hold_off: assert property (p_hold_off) else $error("source moved while locked");
  a_req_zero: assert property (p_req_zero) else $error("request bit set while locked");
  a_cur_mirror: assert property (p_cur_mirror) else $error("current field wrong");
  a_after_tick: assert property (p_after_tick) else $error("switch without tick");
  a_new_on: assert property (p_new_on) else $error("new source not running");
  c_switch: cover property (age == 2'h3 && sys_source != $past(sys_source));
  c_err: cover property (pslverr);
  c_locked_read: cover property (rd_osc && switch_enable_fuse);
endmodule

// ===== testbench/tb_top.sv
// Register-level testbench for the clock switch block
`timescale 1ns/1ps
`include "cswr_defs.svh"
module tb_top
  import cswr_pkg::*;
;
  // ------------------------------------------------------------
  // Signals, clock, design
  // ------------------------------------------------------------
  logic clk;
  logic rst_b;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic err;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rv;
  logic [3:0] pstrb;
  logic switch_enable_fuse;
  logic pll_locked;
  logic new_clk_tick;
  logic clock_fail_event;
  logic sleep_mode;
  logic ref_clock_pin;
  logic pri_clk_tick;
  logic keep_low_power_rc;
  logic [2:0] initial_source_fuse;
  logic [7:0] osc_ready;
  cswr_src_type sys_source;
  cswr_osc_en_type osc_enable;
  int n_errors;
  int checks;
  int p;
  // 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Primary oscillator modelled as a tick on every other clock
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pri_clk_tick <= 1'b0;
    end else begin
      pri_clk_tick <= !pri_clk_tick;
    end
  end
  cswr_top dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .switch_enable_fuse(switch_enable_fuse),
    .initial_source_fuse(initial_source_fuse), .primary_submode_fuse(2'h1),
    .osc_ready(osc_ready), .pll_locked(pll_locked), .new_clk_tick(new_clk_tick),
    .pri_clk_tick(pri_clk_tick), .keep_low_power_rc(keep_low_power_rc),
    .clock_fail_event(clock_fail_event),
    .sleep_mode(sleep_mode), .sys_source(sys_source), .osc_enable(osc_enable),
    .ref_clock_pin(ref_clock_pin));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; holds everything until ready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) n_errors++;
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Unlock pair then value on one byte of the oscillator word
  task osc(input logic hi, input logic [7:0] v);
    logic [4:0] sh;
    sh = hi ? 5'd8 : 5'd0;
    apb(1'b1, `CSWR_OFF_OSC, {24'h00_0000, hi ? `CSWR_KEY_H1 : `CSWR_KEY_L1} << sh, 4'h1 << hi);
    apb(1'b1, `CSWR_OFF_OSC, {24'h00_0000, hi ? `CSWR_KEY_H2 : `CSWR_KEY_L2} << sh, 4'h1 << hi);
    apb(1'b1, `CSWR_OFF_OSC, {24'h00_0000, v} << sh, 4'h1 << hi);
  endtask
  task ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      new_clk_tick <= 1'b1;
      @(posedge clk);
      new_clk_tick <= 1'b0;
    end
  endtask
  task reset(input logic f);
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    switch_enable_fuse <= f;
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task waitv(input logic v, inout int n);
    while (ref_clock_pin !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask
  // Rise-to-rise period in cycles; 400 means the pin stands still
  task per(output int q);
    int n;
    n = 0;
    waitv(1'b0, n);
    waitv(1'b1, n);
    n = 0;
    waitv(1'b0, n);
    waitv(1'b1, n);
    q = n;
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, pll_locked, new_clk_tick, clock_fail_event} = 7'h00;
    {sleep_mode, switch_enable_fuse} = 2'h3;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    osc_ready = 8'hFF;
    keep_low_power_rc = 1'b0;
    initial_source_fuse = 3'h5;
    sleep_mode = 1'b0;
    reset(1'b1);
    apb(1'b0, `CSWR_OFF_CFG, 32'h0000_0000, 4'hF);
    chk(rv[5:0], 6'h1D);
    apb(1'b0, 12'h010, 32'h0000_0000, 4'hF);
    chk(err, 1'b1);
    osc(1'b1, 8'h00);
    osc(1'b0, 8'h01);
    apb(1'b0, `CSWR_OFF_OSC, 32'h0000_0000, 4'hF);
    chk(rv[14:12], 3'h5);
    chk(rv[0], 1'b0);
    chk(sys_source, cswr_src_low_power_rc_osc);
    $display("test locked done");
    initial_source_fuse <= 3'h0;
    reset(1'b0);
    apb(1'b0, `CSWR_OFF_REF, 32'h0000_0000, 4'hF);
    chk(rv[15:0], `CSWR_REF_RESET);
    apb(1'b1, `CSWR_OFF_OSC, 32'h0000_0200, 4'h2);
    apb(1'b1, `CSWR_OFF_OSC, 32'h0000_7800, 4'h2);
    apb(1'b1, `CSWR_OFF_OSC, 32'h0000_9A00, 4'h2);
    apb(1'b1, `CSWR_OFF_REF, 32'h0000_0000, 4'hF);
    apb(1'b1, `CSWR_OFF_OSC, 32'h0000_0200, 4'h2);
    apb(1'b0, `CSWR_OFF_OSC, 32'h0000_0000, 4'hF);
    chk(rv[10:8], 3'h0);
    osc(1'b1, 8'h00);
    osc(1'b0, 8'h01);
    apb(1'b0, `CSWR_OFF_OSC, 32'h0000_0000, 4'hF);
    chk(rv[14:12], 3'h0);
    chk(rv[0], 1'b0);
    $display("test unlock done");
    @(posedge clk);
    clock_fail_event <= 1'b1;
    keep_low_power_rc <= 1'b1;
    @(posedge clk);
    clock_fail_event <= 1'b0;
    osc(1'b1, 8'h01);
    osc(1'b0, 8'h01);
    apb(1'b0, `CSWR_OFF_OSC, 32'h0000_0000, 4'hF);
    chk({rv[5], rv[3], rv[0]}, 3'h1);
    chk(sys_source, cswr_src_frc);
    ticks(12);
    apb(1'b0, `CSWR_OFF_OSC, 32'h0000_0000, 4'hF);
    chk(rv[0], 1'b1);
    pll_locked <= 1'b1;
    repeat (4) @(posedge clk);
    ticks(9);
    apb(1'b0, `CSWR_OFF_OSC, 32'h0000_0000, 4'hF);
    chk(rv[0], 1'b1);
    ticks(1);
    repeat (3) @(posedge clk);
    apb(1'b0, `CSWR_OFF_OSC, 32'h0000_0000, 4'hF);
    chk({rv[14:12], rv[5], rv[0]}, 5'h06);
    chk(osc_enable.run[0], 1'b0);
    chk(osc_enable.run[5], 1'b1);
    $display("test pll switch done");
    osc(1'b1, 8'h02);
    osc(1'b0, 8'h01);
    repeat (950) @(posedge clk);
    ticks(10);
    apb(1'b0, `CSWR_OFF_OSC, 32'h0000_0000, 4'hF);
    chk(rv[0], 1'b1);
    repeat (60) @(posedge clk);
    ticks(10);
    repeat (3) @(posedge clk);
    apb(1'b0, `CSWR_OFF_OSC, 32'h0000_0000, 4'hF);
    chk({rv[14:12], rv[0]}, 4'h4);
    chk(osc_enable.run[1], 1'b0);
    $display("test primary switch done");
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, `CSWR_OFF_REF, {16'h0000, 4'h8, d[3:0], 8'h00}, 4'hF);
      per(p);
      chk(p, (d == 0) ? 2 : (1 << d));
    end
    apb(1'b0, `CSWR_OFF_REF, 32'h0000_0000, 4'hF);
    chk(rv[15:0], 16'h8300);
    apb(1'b1, `CSWR_OFF_REF, 32'h0000_8000, 4'hF);
    @(posedge clk);
    sleep_mode <= 1'b1;
    per(p);
    chk(p, 400);
    apb(1'b1, `CSWR_OFF_REF, 32'h0000_B100, 4'hF);
    per(p);
    chk(p, 4);
    sleep_mode <= 1'b0;
    apb(1'b1, `CSWR_OFF_REF, 32'h0000_0000, 4'hF);
    per(p);
    chk(p, 400);
    $display("test reference done");
    results();
  end
  // Hang guard, well past the few thousand cycles of the tests
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("BAD %0t watchdog", $time);
    results();
  end
endmodule
bind cswr_top cswr_sva chk_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .switch_enable_fuse(switch_enable_fuse), .new_clk_tick(new_clk_tick),
  .sys_source(sys_source), .osc_enable(osc_enable));
